// ==== sim/bus_status_hold_asserts.sv ====
// Checker for the bus status, hold and select front-end
`timescale 1ns/1ps
`include "bus_front_regs.vh"
module bus_status_hold_asserts (
  input wire       sys_clk,
  input wire       rst_n,
  input wire [2:0] cycleType,
  input wire       cycleDone_q,
  input wire       busRequest,
  input wire       bus_grant_out,
  input wire       bus_status_bit0,
  input wire       bus_status_bit1,
  input wire       bus_status_bit2,
  input wire       statusOe,
  input wire       transfer_direction,
  input wire       busCtrlOe,
  input wire       upper_mem_select_n,
  input wire       lower_mem_select_n,
  input wire [3:0] mid_mem_select_n
);
  wire [2:0] st = {bus_status_bit2, bus_status_bit1, bus_status_bit0};
  // --------
  // Properties
  // --------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_grant_floats_bus: assert property (bus_grant_out |-> !statusOe && !busCtrlOe)
    else $error("bus driven while granted");
  a_grant_after_sync: assert property ($rose(bus_grant_out) |-> $past(busRequest, 2))
    else $error("grant without settled request");
  a_grant_drops: assert property ($fell(busRequest) |-> ##[1:8] !bus_grant_out)
    else $error("grant kept after request fell");
  a_status_passive: assert property (statusOe && st != `ST_PASSIVE |=> st == `ST_PASSIVE || !statusOe)
    else $error("status code not back to passive");
  a_status_type: assert property (cycleDone_q |-> $past(st, 4) == $past(cycleType, 5))
    else $error("status code differs from cycle type");
  a_direction_bit: assert property (statusOe && st != `ST_PASSIVE |-> transfer_direction == st[1])
    else $error("direction differs from middle status bit");
  a_mid_one_hot: assert property ($countones(~mid_mem_select_n) <= 1)
    else $error("more than one mid select low");
  a_reset_high: assert property (disable iff (1'b0) !rst_n |=> statusOe && st == `ST_PASSIVE)
    else $error("status not high during reset");
  a_reset_float: assert property (disable iff (1'b0) $rose(rst_n) |=> !statusOe)
    else $error("status not floated after reset");
  c_grant: cover property ($rose(bus_grant_out));
  c_done: cover property (cycleDone_q);
  c_upper: cover property (!upper_mem_select_n);
  c_lower: cover property (!lower_mem_select_n);
endmodule

bind bus_status_hold bus_status_hold_asserts u_chk (.sys_clk, .rst_n, .cycleType, .cycleDone_q, .busRequest,
  .bus_grant_out, .bus_status_bit0, .bus_status_bit1, .bus_status_bit2, .statusOe, .transfer_direction,
  .busCtrlOe, .upper_mem_select_n, .lower_mem_select_n, .mid_mem_select_n);

// ==== sim/other_master.sv ====
// Model of another local bus master asking for the bus
`timescale 1ns/1ps
module other_master (
  // Control and grant
  input  wire       sys_clk,
  input  wire       go,
  input  wire [3:0] holdLen,
  input  wire       grant,
  // Request pin
  output reg        busRequest
);
  reg [3:0] useCnt;
  initial busRequest = 1'b0;
  initial useCnt = 4'h0;
  // Falling edge keeps the request off the sampling edge
  always @(negedge sys_clk) begin
    if (go && !busRequest) begin
      busRequest <= 1'b1;
    end else if (busRequest && grant) begin
      useCnt <= useCnt + 4'h1;
      if (useCnt == holdLen) begin
        busRequest <= 1'b0;
        useCnt     <= 4'h0;
      end
    end
  end
endmodule

// ==== sim/tb_bus_status_hold.sv ====
// Testbench for the bus status, hold and select front-end
`timescale 1ns/1ps
module tb_bus_status_hold;
  reg sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, cycleReq = 1'b0, rangeWrEn = 1'b0, go = 1'b0;
  reg [2:0] cycleType = 3'h0;
  reg [19:0] cycleAddr = 20'h0;
  reg [1:0] rangeSel = 2'h0;
  reg [9:0] rangeData = 10'h0;
  reg [3:0] holdLen = 4'h5;
  wire cycleDone_q, busRequest, bus_grant_out, bus_status_bit0, bus_status_bit1, bus_status_bit2;
  wire statusOe, transfer_direction, busCtrlOe, upper_mem_select_n, lower_mem_select_n;
  wire [3:0] mid_mem_select_n;
  wire [2:0] st = {bus_status_bit2, bus_status_bit1, bus_status_bit0};
  wire [5:0] sels = {upper_mem_select_n, lower_mem_select_n, mid_mem_select_n};
  integer failures = 0, n_compared = 0, cycles = 0;
  always #20 sys_clk = ~sys_clk;
  bus_status_hold dut (.sys_clk, .rst_n, .clkEn, .cycleReq, .cycleType, .cycleAddr, .cycleDone_q, .rangeWrEn,
    .rangeSel, .rangeData, .busRequest, .bus_grant_out, .bus_status_bit0, .bus_status_bit1, .bus_status_bit2,
    .statusOe, .transfer_direction, .busCtrlOe, .upper_mem_select_n, .lower_mem_select_n, .mid_mem_select_n);
  other_master peer (.sys_clk, .go, .holdLen, .grant(bus_grant_out), .busRequest);
  // --------
  // Shared tasks
  // --------
  task end_of_test;
    begin
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [19:0] got, input [19:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        failures = failures + 1;
      end
    end
  endtask
  // Holds the request until the first bus state shows, so a refused request is retried
  task do_cycle(input [2:0] t, input [19:0] a, input [5:0] sel);
    integer i;
    begin
      cycleReq <= 1'b1;
      cycleType <= t;
      cycleAddr <= a;
      for (i = 0; i < 30 && !(statusOe === 1'b1 && st !== 3'h7); i = i + 1) @(negedge sys_clk);
      cycleReq <= 1'b0;
      check(st, t);
      check(transfer_direction, t[1]);
      check(busCtrlOe, 1'b1);
      @(negedge sys_clk);
      check(st, 3'h7);
      check(sels, sel);
      for (i = 0; i < 8 && cycleDone_q !== 1'b1; i = i + 1) @(negedge sys_clk);
      check(cycleDone_q, 1'b1);
    end
  endtask
  task t_reset;
    begin
      repeat (10) @(negedge sys_clk);
      check({statusOe, st}, 4'hf);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      check(statusOe, 1'b0);
    end
  endtask
  task t_types;
    integer i;
    begin
      for (i = 0; i < 7; i = i + 1) do_cycle(i[2:0], 20'h00100, i[2] ? 6'h2f : 6'h3f);
    end
  endtask
  // Clock enable low must hold off a waiting cycle
  task t_freeze;
    integer i;
    begin
      @(negedge sys_clk);
      clkEn <= 1'b0;
      cycleReq <= 1'b1;
      cycleType <= 3'h1;
      cycleAddr <= 20'h00100;
      for (i = 0; i < 4; i = i + 1) begin
        @(negedge sys_clk);
        check({statusOe, st}, 4'hf);
      end
      clkEn <= 1'b1;
      do_cycle(3'h1, 20'h00100, 6'h3f);
    end
  endtask
  // Request settles during a cycle, so the grant lands at its last state
  task t_hold_end;
    integer i;
    begin
      go <= 1'b1;
      @(negedge sys_clk);
      go <= 1'b0;
      do_cycle(3'h5, 20'h00100, 6'h2f);
      check(bus_grant_out, 1'b1);
      check({statusOe, busCtrlOe}, 2'h0);
      @(negedge sys_clk);
      check(sels, 6'h3f);
      for (i = 0; i < 20 && bus_grant_out !== 1'b0; i = i + 1) @(negedge sys_clk);
      check(bus_grant_out, 1'b0);
    end
  endtask
  task t_selects;
    begin
      do_cycle(3'h5, 20'hff000, 6'h1f);
      do_cycle(3'h5, 20'h20800, 6'h3d);
      do_cycle(3'h6, 20'h21800, 6'h37);
      rangeWrEn <= 1'b1;
      rangeData <= 10'h3f0;
      @(negedge sys_clk);
      rangeWrEn <= 1'b0;
      do_cycle(3'h6, 20'hfc000, 6'h1f);
    end
  endtask
  task t_hold;
    integer i;
    begin
      go <= 1'b1;
      @(negedge sys_clk);
      go <= 1'b0;
      for (i = 0; i < 20 && bus_grant_out !== 1'b1; i = i + 1) @(negedge sys_clk);
      check(bus_grant_out, 1'b1);
      check({statusOe, busCtrlOe}, 2'h0);
      check(sels, 6'h3f);
      do_cycle(3'h4, 20'h00000, 6'h2f);
      check(bus_grant_out, 1'b0);
    end
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial begin
    t_reset;
    t_types;
    t_selects;
    t_freeze;
    t_hold;
    t_hold_end;
    end_of_test;
  end
endmodule

// ==== src/bus_front_regs.vh ====
// Constants for the local bus front-end: status codes, status bit positions, decode layout
`ifndef BUS_FRONT_REGS_VH
`define BUS_FRONT_REGS_VH

`define ST_INTA      3'h0
`define ST_IO_RD     3'h1
`define ST_IO_WR     3'h2
`define ST_HALT      3'h3
`define ST_FETCH     3'h4
`define ST_MEM_RD    3'h5
`define ST_MEM_WR    3'h6
`define ST_PASSIVE   3'h7
`define ST_MEM_BIT   2
`define ST_DIR_BIT   1

`define ADDR_W       20
`define BLK_W        10
`define UPPER_BASE_RST 10'h3fc
`define LOWER_TOP_RST  10'h003
`define MID_BASE_RST   10'h080
`define MID_SIZE_RST   10'h008
`define MID_SEL_LSB  0

`endif

// ==== src/bus_status_hold.v ====
// Bus cycle status, hold/grant handshake and chip select front-end
`timescale 1ns/1ps
`include "bus_front_regs.vh"
// How it works
// - Status code per bus cycle type
// - Idle bus after a cycle shows passive code 111
// - Top bit memory, middle bit direction
// - Status floats while bus granted
// - High one clock at reset, then float
// - Request may be asynchronous to clock
// - Grant only at last bus state or in idle
// - Float bus with grant same cycle
// - Request low drops the grant
// - Drive bus again for next cycle
// - Upper select for top block
// - Lower select for bottom block
// - One of four mid selects
// - Selects stay driven during grant
// - Select ranges set by software
module bus_status_hold (
  // Clock and reset
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  clkEn,
  // Core cycle request
  input  wire                  cycleReq,
  input  wire [2:0]            cycleType,
  input  wire [`ADDR_W-1:0]    cycleAddr,
  output reg                   cycleDone_q,
  // Range setup from software
  input  wire                  rangeWrEn,
  input  wire [1:0]            rangeSel,
  input  wire [`BLK_W-1:0]     rangeData,
  // Other master
  input  wire                  busRequest,
  output reg                   bus_grant_out,
  // Status pins
  output reg                   bus_status_bit0,
  output reg                   bus_status_bit1,
  output reg                   bus_status_bit2,
  output reg                   statusOe,
  output reg                   transfer_direction,
  output reg                   busCtrlOe,
  // Memory selects
  output wire                  upper_mem_select_n,
  output wire                  lower_mem_select_n,
  output wire [3:0]            mid_mem_select_n
);
  // ----------------------------------------
  // Bus states, one-hot
  // ----------------------------------------
  localparam [4:0] S_IDLE   = 5'h01;
  localparam [4:0] S_FIRST  = 5'h02;
  localparam [4:0] S_SECOND = 5'h04;
  localparam [4:0] S_THIRD  = 5'h08;
  localparam [4:0] S_LAST   = 5'h10;

  reg [4:0]          state_q;
  reg [2:0]          type_q;
  reg [`ADDR_W-1:0]  addr_q;
  reg                rstHigh_q;
  reg [2:0]          reqSync_q;
  reg                reqSeen_q;
  reg [`BLK_W-1:0]   upperBase_q;
  reg [`BLK_W-1:0]   lowerTop_q;
  reg [`BLK_W-1:0]   midBase_q;
  reg [`BLK_W-1:0]   midSize_q;

  // ----------------------------------------
  // Request synchroniser
  // ----------------------------------------
  // Three stages; a change is taken once stages two and three agree
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reqSync_q <= 3'h0;
      reqSeen_q <= 1'b0;
    end else if (clkEn) begin
      reqSync_q <= {reqSync_q[1:0], busRequest};
      if (reqSync_q[1] == reqSync_q[2]) begin
        reqSeen_q <= reqSync_q[2];
      end
    end
  end

  // ----------------------------------------
  // Range registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      upperBase_q <= `UPPER_BASE_RST;
      lowerTop_q  <= `LOWER_TOP_RST;
      midBase_q   <= `MID_BASE_RST;
      midSize_q   <= `MID_SIZE_RST;
    end else if (clkEn && rangeWrEn) begin
      // Reset map stays usable until software rewrites a range
      case (rangeSel)
        2'd0: upperBase_q <= rangeData;
        2'd1: lowerTop_q  <= rangeData;
        2'd2: midBase_q   <= rangeData;
        default: midSize_q <= rangeData;
      endcase
    end
  end

  // ----------------------------------------
  // Grant and start qualifiers
  // ----------------------------------------
  // Grant may only start where a cycle ends or before the next one commits
  wire cycleEnd  = (state_q == S_LAST);
  wire grantSlot = (state_q == S_IDLE) || cycleEnd;
  wire takeGrant = reqSeen_q && !bus_grant_out && grantSlot;
  wire startOk   = cycleReq && !reqSeen_q && !bus_grant_out;

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  // A pending grant outranks a waiting core cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q            <= S_IDLE;
      type_q             <= `ST_PASSIVE;
      addr_q             <= {`ADDR_W{1'b0}};
      rstHigh_q          <= 1'b1;
      cycleDone_q        <= 1'b0;
      bus_grant_out      <= 1'b0;
      bus_status_bit0    <= 1'b1;
      bus_status_bit1    <= 1'b1;
      bus_status_bit2    <= 1'b1;
      statusOe           <= 1'b1;
      transfer_direction <= 1'b0;
      busCtrlOe          <= 1'b0;
    end else if (clkEn) begin
      cycleDone_q <= 1'b0;
      rstHigh_q   <= 1'b0;
      // Status held high for the first clock after reset, then floated
      if (rstHigh_q) begin
        statusOe <= 1'b0;
      end
      if (takeGrant) begin
        bus_grant_out <= 1'b1;
        busCtrlOe     <= 1'b0;
        statusOe      <= 1'b0;
        state_q       <= S_IDLE;
        type_q        <= `ST_PASSIVE;
        // A cycle cut off at its last state still reports completion
        if (cycleEnd) begin
          cycleDone_q <= 1'b1;
        end
      end else if (bus_grant_out) begin
        // Grant stays up until the settled request reads low
        if (!reqSeen_q) begin
          bus_grant_out <= 1'b0;
        end
      end else begin
        case (state_q)
          S_IDLE: begin
            if (startOk) begin
              state_q  <= S_FIRST;
              type_q   <= cycleType;
              addr_q   <= cycleAddr;
              statusOe <= 1'b1;
              busCtrlOe <= 1'b1;
              {bus_status_bit2, bus_status_bit1, bus_status_bit0} <= cycleType;
              transfer_direction <= cycleType[`ST_DIR_BIT];
            end
          end
          S_FIRST: begin
            // Code shown for one state only, passive from then on
            state_q <= S_SECOND;
            {bus_status_bit2, bus_status_bit1, bus_status_bit0} <= `ST_PASSIVE;
          end
          S_SECOND: begin
            state_q <= S_THIRD;
          end
          S_THIRD: begin
            state_q <= S_LAST;
          end
          S_LAST: begin
            cycleDone_q <= 1'b1;
            type_q      <= `ST_PASSIVE;
            if (startOk) begin
              state_q  <= S_FIRST;
              type_q   <= cycleType;
              addr_q   <= cycleAddr;
              statusOe  <= 1'b1;
              busCtrlOe <= 1'b1;
              {bus_status_bit2, bus_status_bit1, bus_status_bit0} <= cycleType;
              transfer_direction <= cycleType[`ST_DIR_BIT];
            end else begin
              state_q <= S_IDLE;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Memory selects, never floated
  // ----------------------------------------
  // Selects follow the latched cycle and are idled, not floated, on a grant
  wire memRef = (type_q[`ST_MEM_BIT] == 1'b1) && (type_q != `ST_PASSIVE);

  mem_select_decode u_decode (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .clkEn       (clkEn),
    .memRef      (memRef),
    .addr        (addr_q),
    .upperBase   (upperBase_q),
    .lowerTop    (lowerTop_q),
    .midBase     (midBase_q),
    .midSize     (midSize_q),
    .upperSelN_q (upper_mem_select_n),
    .lowerSelN_q (lower_mem_select_n),
    .midSelN_q   (mid_mem_select_n)
  );
endmodule

// ==== src/mem_select_decode.v ====
// Registered memory select decode for upper, lower and mid-range blocks
`timescale 1ns/1ps
`include "bus_front_regs.vh"
module mem_select_decode (
  // Clock and reset
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  clkEn,
  // Reference
  input  wire                  memRef,
  input  wire [`ADDR_W-1:0]    addr,
  // Range setup, 1K granules
  input  wire [`BLK_W-1:0]     upperBase,
  input  wire [`BLK_W-1:0]     lowerTop,
  input  wire [`BLK_W-1:0]     midBase,
  input  wire [`BLK_W-1:0]     midSize,
  // Selects
  output reg                   upperSelN_q,
  output reg                   lowerSelN_q,
  output reg  [3:0]            midSelN_q
);
  wire [`BLK_W-1:0] blk = addr[`ADDR_W-1:`ADDR_W-`BLK_W];
  wire [`BLK_W-1:0] midOff = blk - midBase;
  wire              inMid = memRef && (blk >= midBase) && (midOff < midSize);
  wire [1:0]        quarter;
  wire [`BLK_W+1:0] offX4 = {midOff, 2'b00};
  wire [3:0]        quarterHot = 4'h1 << quarter;

  // Quarter of mid region: offset*4 compared against size
  assign quarter = (offX4 >= {midSize, 1'b0} + {2'b00, midSize}) ? 2'd3 :
                   (offX4 >= {1'b0, midSize, 1'b0}) ? 2'd2 :
                   (offX4 >= {2'b00, midSize}) ? 2'd1 : 2'd0;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_mid
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          midSelN_q[i] <= 1'b1;
        end else if (clkEn) begin
          midSelN_q[i] <= !(inMid && quarterHot[i]);
        end
      end
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      upperSelN_q <= 1'b1;
      lowerSelN_q <= 1'b1;
    end else if (clkEn) begin
      upperSelN_q <= !(memRef && blk >= upperBase);
      lowerSelN_q <= !(memRef && blk <= lowerTop);
    end
  end
endmodule
